// >>> hw/hbw_defs.vh
// Constants for the half-bridge waveform generator: register map, fields,
// counter loads and default timer lengths in controller clock cycles.
// Assumes a 200 MHz controller clock and a 32-bit AXI4-Lite register bus.
`ifndef HBW_DEFS_VH
`define HBW_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HBW_CTRL_OFS        8'h00
`define HBW_STATUS_OFS      8'h04
`define HBW_CYCLES_OFS      8'h08

// ****************************************************************
// Register fields
// ****************************************************************
`define HBW_CTRL_MATCH_BIT  0
`define HBW_CTRL_RST_VAL    1'h0
`define HBW_ST_STATE_LSB    0
`define HBW_ST_OUT_LSB      3
`define HBW_ST_START_LSB    8
`define HBW_ST_BURST_LSB    12
`define HBW_ST_OCP_LSB      16
`define HBW_ST_OVP_LSB      20

// ****************************************************************
// Counter loads
// ****************************************************************
`define HBW_STARTUP_LOAD    4'hf
`define HBW_BURST_LOAD      4'hf
`define HBW_OCP_LOAD        4'h4
`define HBW_OVP_LOAD        4'h4

// ****************************************************************
// Default timer lengths, controller clock cycles
// ****************************************************************
`define HBW_IDLE_MIN_CYC    200
`define HBW_WAKE_CYC        400
`define HBW_ON_MIN_CYC      40
`define HBW_ON_MAX_CYC      4000
`define HBW_DT_MAX_CYC      200
`define HBW_DT_START_CYC    100

// ****************************************************************
// Synchronised input bit positions
// ****************************************************************
`define HBW_IN_FB           0
`define HBW_IN_LTH          1
`define HBW_IN_HTH          2
`define HBW_IN_CM           3
`define HBW_IN_RSLEW        4
`define HBW_IN_FSLEW        5
`define HBW_IN_POL          6
`define HBW_IN_OCP          7
`define HBW_IN_OVP          8
`define HBW_IN_ZCS          9
`define HBW_IN_NUM          10

`endif

// >>> hw/hbw_wavegen.v
// Half-bridge waveform generator: six-state gate sequencer with an AXI4-Lite
// register slave. Assumes the analog comparators arrive asynchronously on pins,
// while the generator enable and the matched dead-time result come from logic
// on the same clock.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "hbw_defs.vh"

module hbw_wavegen #(
  parameter IDLE_MIN_CYC = `HBW_IDLE_MIN_CYC,
  parameter WAKE_CYC     = `HBW_WAKE_CYC,
  parameter ON_MIN_CYC   = `HBW_ON_MIN_CYC,
  parameter ON_MAX_CYC   = `HBW_ON_MAX_CYC,
  parameter DT_MAX_CYC   = `HBW_DT_MAX_CYC,
  parameter DT_START_CYC = `HBW_DT_START_CYC
) (
  input  wire        clk_i,
  input  wire        arst_n_i,
  // Power stage and fault logic
  input  wire        generator_enable_i,
  input  wire        feedback_below_burst_threshold_i,
  input  wire        cap_volt_below_low_thr_i,
  input  wire        cap_volt_above_high_thr_i,
  input  wire        cap_volt_above_common_mode_i,
  input  wire        rise_slew_complete_i,
  input  wire        fall_slew_complete_i,
  input  wire        current_sign_i,
  input  wire        overcurrent_level_one_i,
  input  wire        bias_overvoltage_i,
  input  wire        zero_current_detect_i,
  input  wire        matched_dead_time_elapsed_i,
  output reg         high_gate_cmd_o,
  output reg         low_gate_cmd_o,
  output reg         high_ramp_enable_o,
  output reg         low_ramp_enable_o,
  output reg         zero_current_flag_o,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i
);

  // ****************************************************************
  // States and timer thresholds
  // ****************************************************************
  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_WAKE    = 3'h1;
  localparam [2:0] ST_LOW_ON  = 3'h2;
  localparam [2:0] ST_DEAD_LH = 3'h3;
  localparam [2:0] ST_HIGH_ON = 3'h4;
  localparam [2:0] ST_DEAD_HL = 3'h5;

  // Timer "done" once the state has lasted the given number of cycles
  localparam [15:0] IDLE_MIN_M1 = IDLE_MIN_CYC[15:0] - 16'h0001;
  localparam [15:0] WAKE_M1     = WAKE_CYC[15:0] - 16'h0001;
  localparam [15:0] ON_MIN_M1   = ON_MIN_CYC[15:0] - 16'h0001;
  localparam [15:0] ON_MAX_M1   = ON_MAX_CYC[15:0] - 16'h0001;
  localparam [15:0] DT_MAX_M1   = DT_MAX_CYC[15:0] - 16'h0001;
  localparam [15:0] DT_START_M1 = DT_START_CYC[15:0] - 16'h0001;
  localparam [15:0] CNT_MAX     = 16'hffff;
  localparam        NI          = `HBW_IN_NUM;

  // ****************************************************************
  // Pin synchroniser with agreement filter
  // ****************************************************************
  reg  [NI-1:0] sync1_r;
  reg  [NI-1:0] sync2_r;
  reg  [NI-1:0] sync3_r;
  reg  [NI-1:0] flt_r;
  wire [NI-1:0] flt_nxt;
  wire [NI-1:0] differ;

  // Packed from bit 9 down to bit 0, in the order of the input position constants
  wire [NI-1:0] pins_raw = {zero_current_detect_i, bias_overvoltage_i, overcurrent_level_one_i,
                            current_sign_i, fall_slew_complete_i, rise_slew_complete_i,
                            cap_volt_above_common_mode_i, cap_volt_above_high_thr_i,
                            cap_volt_below_low_thr_i, feedback_below_burst_threshold_i};

  // A bit moves only when the second and third stages agree
  assign differ  = sync2_r ^ sync3_r;
  assign flt_nxt = (sync3_r & ~differ) | (flt_r & differ);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= {NI{1'b0}};
      sync2_r <= {NI{1'b0}};
      sync3_r <= {NI{1'b0}};
      flt_r   <= {NI{1'b0}};
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      flt_r   <= flt_nxt;
    end
  end

  wire fb_below  = flt_r[`HBW_IN_FB];
  wire vcr_low   = flt_r[`HBW_IN_LTH];
  wire vcr_high  = flt_r[`HBW_IN_HTH];
  wire vcr_cm    = flt_r[`HBW_IN_CM];
  wire rise_slew = flt_r[`HBW_IN_RSLEW];
  wire fall_slew = flt_r[`HBW_IN_FSLEW];
  wire ocp_now   = flt_r[`HBW_IN_OCP];
  wire ovp_now   = flt_r[`HBW_IN_OVP];
  wire zcs_now   = flt_r[`HBW_IN_ZCS];

  // ****************************************************************
  // Control, state and counter registers
  // ****************************************************************
  reg         match_en_r;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [15:0] cnt_r;
  reg  [3:0]  startup_r;
  reg  [3:0]  burst_r;
  reg  [3:0]  ocp_r;
  reg  [3:0]  ovp_r;
  reg  [15:0] cycles_r;
  reg         ocp_seen_r;
  reg         ovp_seen_r;
  reg         en_d_r;
  reg         rise_pend_r;
  reg         pol_d_r;

  // ****************************************************************
  // Event detection and timers
  // ****************************************************************
  wire en             = generator_enable_i;
  wire en_rise        = en & ~en_d_r;
  wire current_sign_fall_seen = pol_d_r & ~flt_r[`HBW_IN_POL];
  wire idle_min_done  = cnt_r >= IDLE_MIN_M1;
  wire wake_done      = cnt_r >= WAKE_M1;
  wire on_min_done    = cnt_r >= ON_MIN_M1;
  wire on_max_done    = cnt_r >= ON_MAX_M1;
  wire dead_time_max_done      = cnt_r >= DT_MAX_M1;
  wire startup_dead_clamp_done = cnt_r >= DT_START_M1;
  wire startup_count_done      = startup_r == 4'h0;
  wire burst_count_done        = burst_r == 4'h0;
  wire ocp_done       = ocp_r == 4'h0;
  wire ovp_done       = ovp_r == 4'h0;

  // Startup clamp only helps while the startup counter is still running
  wire clamp_exit = ~startup_count_done & startup_dead_clamp_done;
  wire ls_exit    = (vcr_low | on_max_done) & on_min_done;
  wire hs_exit    = (vcr_high | on_max_done) & on_min_done;
  wire rise_ok    = match_en_r ? (rise_slew & matched_dead_time_elapsed_i)
                               : rise_slew;
  wire lh_dead_exit = clamp_exit | dead_time_max_done | rise_ok
                  | current_sign_fall_seen;
  wire hl_dead_exit = clamp_exit | dead_time_max_done | fall_slew
                  | current_sign_fall_seen;
  wire burst_off  = burst_count_done & vcr_cm & fb_below & on_min_done;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (en && !fb_below && idle_min_done)
          state_nxt = ST_WAKE;
      ST_WAKE: if (!en)
          state_nxt = ST_IDLE;
        else if (wake_done)
          state_nxt = ST_LOW_ON;
      ST_LOW_ON: if (!en || (ls_exit && (ocp_done || ovp_done)))
          state_nxt = ST_IDLE;
        else if (ls_exit)
          state_nxt = ST_DEAD_LH;
      ST_DEAD_LH: if (!en)
          state_nxt = ST_IDLE;
        else if (lh_dead_exit)
          state_nxt = ST_HIGH_ON;
      ST_HIGH_ON: if (!en || burst_off)
          state_nxt = ST_IDLE;
        else if (hs_exit)
          state_nxt = ST_DEAD_HL;
      ST_DEAD_HL: if (!en)
          state_nxt = ST_IDLE;
        else if (hl_dead_exit)
          state_nxt = ST_LOW_ON;
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire idle_entry = (state_nxt == ST_IDLE) && (state_r != ST_IDLE);
  // One switching cycle closes when high-to-low dead time hands back to low side
  wire cycle_end  = (state_r == ST_DEAD_HL) && (state_nxt == ST_LOW_ON);
  wire st_change  = state_nxt != state_r;

  // ****************************************************************
  // State, state timer and cycle counters
  // ****************************************************************
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 16'h0000;
      startup_r   <= 4'h0;
      burst_r     <= `HBW_BURST_LOAD;
      ocp_r       <= `HBW_OCP_LOAD;
      ovp_r       <= `HBW_OVP_LOAD;
      cycles_r    <= 16'h0000;
      ocp_seen_r  <= 1'b0;
      ovp_seen_r  <= 1'b0;
      en_d_r      <= 1'b0;
      rise_pend_r <= 1'b0;
      pol_d_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_d_r  <= en;
      pol_d_r <= flt_r[`HBW_IN_POL];
      // Timer restarts on every state change, so each state times itself
      if (st_change)
        cnt_r <= 16'h0000;
      else if (cnt_r != CNT_MAX)
        cnt_r <= cnt_r + 16'h0001;
      // A rise arriving while the load happens stays pending
      if (state_r == ST_IDLE && rise_pend_r) begin
        startup_r   <= `HBW_STARTUP_LOAD;
        rise_pend_r <= en_rise;
      end else begin
        rise_pend_r <= rise_pend_r | en_rise;
        if (cycle_end && !startup_count_done)
          startup_r <= startup_r - 4'h1;
      end
      if (idle_entry) begin
        burst_r    <= `HBW_BURST_LOAD;
        ocp_r      <= `HBW_OCP_LOAD;
        ovp_r      <= `HBW_OVP_LOAD;
        cycles_r   <= 16'h0000;
        ocp_seen_r <= 1'b0;
        ovp_seen_r <= 1'b0;
      end else if (cycle_end) begin
        if (!burst_count_done)
          burst_r <= burst_r - 4'h1;
        if ((ocp_seen_r || ocp_now) && !ocp_done)
          ocp_r <= ocp_r - 4'h1;
        if ((ovp_seen_r || ovp_now) && !ovp_done)
          ovp_r <= ovp_r - 4'h1;
        cycles_r   <= cycles_r + 16'h0001;
        ocp_seen_r <= 1'b0;
        ovp_seen_r <= 1'b0;
      end else begin
        ocp_seen_r <= ocp_seen_r | ocp_now;
        ovp_seen_r <= ovp_seen_r | ovp_now;
      end
    end
  end

  // ****************************************************************
  // Gate, ramp and zero-current outputs
  // ****************************************************************
  // Decoded from the next state so the registered outputs line up with state_r
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_gate_cmd_o     <= 1'b0;
      low_gate_cmd_o      <= 1'b0;
      high_ramp_enable_o  <= 1'b0;
      low_ramp_enable_o   <= 1'b0;
      zero_current_flag_o <= 1'b0;
    end else begin
      low_gate_cmd_o      <= state_nxt == ST_LOW_ON;
      high_gate_cmd_o     <= state_nxt == ST_HIGH_ON;
      low_ramp_enable_o   <= (state_nxt == ST_LOW_ON) || (state_nxt == ST_DEAD_HL);
      high_ramp_enable_o  <= (state_nxt == ST_HIGH_ON) || (state_nxt == ST_DEAD_LH);
      // Idle and wake-up force the flag low
      zero_current_flag_o <= zcs_now && (state_nxt != ST_IDLE)
                          && (state_nxt != ST_WAKE);
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg         aw_held_r;
  reg         w_held_r;
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg  [31:0] rd_word;
  reg         rd_hit;

  // Each channel is taken once and held until the response has gone
  assign s_axi_awready_o = ~aw_held_r & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held_r & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
  wire aw_have = aw_held_r | aw_take;
  wire w_have  = w_held_r | w_take;
  wire [7:0]  wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr_i;
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata_i;
  wire [3:0]  wr_strb = w_held_r ? wstrb_r : s_axi_wstrb_i;
  wire        wr_go   = aw_have & w_have & ~s_axi_bvalid_o;
  wire        wr_hit  = (wr_addr == `HBW_CTRL_OFS) || (wr_addr == `HBW_STATUS_OFS)
                      || (wr_addr == `HBW_CYCLES_OFS);

  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr_i)
      `HBW_CTRL_OFS:   rd_word[`HBW_CTRL_MATCH_BIT] = match_en_r;
      `HBW_STATUS_OFS: begin
        rd_word[`HBW_ST_STATE_LSB +: 3] = state_r;
        rd_word[`HBW_ST_OUT_LSB +: 5]   = {zero_current_flag_o, low_ramp_enable_o,
                                           high_ramp_enable_o, low_gate_cmd_o, high_gate_cmd_o};
        rd_word[`HBW_ST_START_LSB +: 4] = startup_r;
        rd_word[`HBW_ST_BURST_LSB +: 4] = burst_r;
        rd_word[`HBW_ST_OCP_LSB +: 4]   = ocp_r;
        rd_word[`HBW_ST_OVP_LSB +: 4]   = ovp_r;
      end
      `HBW_CYCLES_OFS: rd_word[15:0] = cycles_r;
      default:         rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_r      <= 1'b0;
      w_held_r       <= 1'b0;
      awaddr_r       <= 8'h00;
      wdata_r        <= 32'h0000_0000;
      wstrb_r        <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= 2'h0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= 2'h0;
      s_axi_rdata_o  <= 32'h0000_0000;
      match_en_r     <= `HBW_CTRL_RST_VAL;
    end else begin
      if (aw_take)
        awaddr_r <= s_axi_awaddr_i;
      if (w_take) begin
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held_r      <= 1'b0;
        w_held_r       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Unmapped offsets answer SLVERR; status and cycle words are read-only
        s_axi_bresp_o  <= wr_hit ? 2'h0 : 2'h2;
        if (wr_addr == `HBW_CTRL_OFS && wr_strb[0])
          match_en_r <= wr_data[`HBW_CTRL_MATCH_BIT];
      end else begin
        aw_held_r <= aw_have;
        w_held_r  <= w_have;
        if (s_axi_bvalid_o && s_axi_bready_i)
          s_axi_bvalid_o <= 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_word;
        s_axi_rresp_o  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule // hbw_wavegen

// >>> tb/hbw_wavegen_asserts.sv
// Port checker for the half-bridge waveform generator, bound onto its top.
// Assumes the timer parameters are handed on by the bind below.
`timescale 1ns/1ps
module hbw_wavegen_chk #(
  parameter int ON_MIN_CYC = 4,
  parameter int ON_MAX_CYC = 20,
  parameter int DT_MAX_CYC = 8
) (
  input logic clk_i,
  input logic arst_n_i,
  input logic generator_enable_i,
  input logic high_gate_cmd_o,
  input logic low_gate_cmd_o,
  input logic high_ramp_enable_o,
  input logic low_ramp_enable_o,
  input logic zero_current_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_low_on_ramps: assert property (low_gate_cmd_o |->
    low_ramp_enable_o && !high_ramp_enable_o && !high_gate_cmd_o) else $error("low side mix");
  a_high_on_ramps: assert property (high_gate_cmd_o |->
    high_ramp_enable_o && !low_ramp_enable_o) else $error("high side mix");
  a_ramps_apart: assert property (!(high_ramp_enable_o && low_ramp_enable_o))
    else $error("both ramps on");
  a_zcf_active: assert property (zero_current_flag_o |->
    high_ramp_enable_o || low_ramp_enable_o) else $error("flag outside active states");
  a_enable_abort: assert property (!generator_enable_i |=>
    !(high_ramp_enable_o || low_ramp_enable_o)) else $error("no abort on enable low");
  a_high_from_dead: assert property ($rose(high_gate_cmd_o) |->
    $past(high_ramp_enable_o)) else $error("high gate not after dead time");
  a_dead_lh_max: assert property ($fell(low_gate_cmd_o) |-> ##[1:DT_MAX_CYC]
    (high_gate_cmd_o || !high_ramp_enable_o)) else $error("dead time too long");
  a_dead_hl_max: assert property ($fell(high_gate_cmd_o) |-> ##[1:DT_MAX_CYC]
    (low_gate_cmd_o || !low_ramp_enable_o)) else $error("dead time too long");
  a_high_min_on: assert property ($fell(high_gate_cmd_o) && $past(generator_enable_i)
    |-> $past(high_gate_cmd_o, ON_MIN_CYC)) else $error("high on too short");
  a_high_max_on: assert property ($rose(high_gate_cmd_o) |->
    ##[1:ON_MAX_CYC] !high_gate_cmd_o) else $error("high on too long");
endmodule // hbw_wavegen_chk

bind hbw_wavegen hbw_wavegen_chk #(.ON_MIN_CYC(ON_MIN_CYC), .ON_MAX_CYC(ON_MAX_CYC),
  .DT_MAX_CYC(DT_MAX_CYC)) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .generator_enable_i(generator_enable_i), .high_gate_cmd_o(high_gate_cmd_o),
  .low_gate_cmd_o(low_gate_cmd_o), .high_ramp_enable_o(high_ramp_enable_o),
  .low_ramp_enable_o(low_ramp_enable_o), .zero_current_flag_o(zero_current_flag_o));

// >>> tb/hbw_stage_model.sv
// Behavioural power stage: threshold, slew and zero-current comparators answer a few cycles into each state.
// Assumes the generator's gate and ramp outputs and the slow switch are its only stimulus.
`timescale 1ns/1ps
module hbw_stage_model (
  input  logic clk_i,
  input  logic slow_i,
  input  logic hg_i,
  input  logic lg_i,
  input  logic hr_i,
  input  logic lr_i,
  output logic lth_o,
  output logic hth_o,
  output logic cm_o,
  output logic rs_o,
  output logic fs_o,
  output logic sg_o,
  output logic zc_o
);
  logic [3:0] st  = 4'h0;
  logic [3:0] age = 4'h0;
  // Slow mode silences the threshold, slew and zero-current outputs, so the generator's timers and the current sign end a state
  wire ripe = (age >= 4'h3) && !slow_i;
  always @(posedge clk_i) begin
    st  <= {hg_i, lg_i, hr_i, lr_i};
    age <= (st != {hg_i, lg_i, hr_i, lr_i}) ? 4'h0 : age + {3'h0, age != 4'hf};
  end
  assign lth_o = lg_i && ripe;
  assign hth_o = hg_i && ripe;
  assign cm_o  = hg_i;
  assign rs_o  = hr_i && !hg_i && ripe;
  assign fs_o  = lr_i && !lg_i && ripe;
  assign sg_o  = hg_i || hr_i;
  assign zc_o  = lg_i && ripe;
endmodule // hbw_stage_model

// >>> tb/hbw_wavegen_tb_top.sv
// Register-driven testbench for the half-bridge waveform generator.
// Assumes the stage model on the comparator pins and small timer values.
`timescale 1ns/1ps
`include "hbw_defs.vh"
module hbw_wavegen_tb_top;
  // Feedback starts below the burst level so that raising enable alone keeps the machine idle
  logic clk_i = 1'b0, arst_n_i = 1'b0, en = 1'b0, fb = 1'b1, slow = 1'b0, mdt = 1'b0;
  logic zf_seen = 1'b0;
  logic [3:0] ws = 4'hf;
  logic ocp = 1'b0, bias_overvoltage = 1'b0, brd = 1'b1, rrd = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic lth, hth, cm, rs, fs, sg, zc, hg, lg, hr, lr, zf, awr, wr, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, d;
  logic [1:0] brsp, rrsp, r;
  int n_fail = 0, checks_done = 0;

  hbw_wavegen #(.IDLE_MIN_CYC(4), .WAKE_CYC(4), .ON_MIN_CYC(4), .ON_MAX_CYC(20),
    .DT_MAX_CYC(8), .DT_START_CYC(4)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .generator_enable_i(en), .feedback_below_burst_threshold_i(fb),
    .cap_volt_below_low_thr_i(lth), .cap_volt_above_high_thr_i(hth),
    .cap_volt_above_common_mode_i(cm), .rise_slew_complete_i(rs),
    .fall_slew_complete_i(fs), .current_sign_i(sg), .overcurrent_level_one_i(ocp),
    .bias_overvoltage_i(bias_overvoltage), .zero_current_detect_i(zc), .matched_dead_time_elapsed_i(mdt),
    .high_gate_cmd_o(hg), .low_gate_cmd_o(lg), .high_ramp_enable_o(hr),
    .low_ramp_enable_o(lr), .zero_current_flag_o(zf), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(brsp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(brd), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rrsp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rrd));
  hbw_stage_model u_stage (.clk_i(clk_i), .slow_i(slow), .hg_i(hg), .lg_i(lg), .hr_i(hr),
    .lr_i(lr), .lth_o(lth), .hth_o(hth), .cm_o(cm), .rs_o(rs), .fs_o(fs), .sg_o(sg),
    .zc_o(zc));

  initial forever #2.5 clk_i = ~clk_i;

  // Remembers that the zero-current flag was raised at least once
  always @(posedge clk_i) begin
    if (zf)
      zf_seen <= 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready levels are looked at on the falling edge, the last settled point before sampling
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs_);
    logic ta, tw, g;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = awv && awr;
      tw = wv && wr;
      g = bv;
      rs_ = brsp;
      @(posedge clk_i);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!g);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs_);
    logic t, g;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(negedge clk_i);
      t = arv && arr;
      g = rv;
      dv = rd;
      rs_ = rrsp;
      @(posedge clk_i);
      if (t) arv <= 1'b0;
    end while (!g);
  endtask
  task automatic wst(input logic [2:0] s);
    int n = 0;
    do begin
      axr(`HBW_STATUS_OFS, d, r);
      n++;
    end while (d[2:0] !== s && n < 3000);
    chk(32'(d[2:0]), 32'(s));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(32'({hg, lg, hr, lr, zf}), 32'h0);
    axr(`HBW_CTRL_OFS, d, r);
    chk(d, 32'h0);
    axr(8'h0c, d, r);
    chk(32'(r), 32'h2);
    axw(8'h0c, 32'h1, r);
    chk(32'(r), 32'h2);
    $display("test reset done");
    en <= 1'b1;
    repeat (30) @(posedge clk_i);
    axr(`HBW_STATUS_OFS, d, r);
    chk({8'h0, d[23:0]}, {8'h0, `HBW_OVP_LOAD, `HBW_OCP_LOAD, `HBW_BURST_LOAD,
      `HBW_STARTUP_LOAD, 8'h00});
    fb <= 1'b0;
    wst(3'd2);
    repeat (1200) @(posedge clk_i);
    axr(`HBW_STATUS_OFS, d, r);
    chk(32'(d[15:8]), 32'h0);
    fb <= 1'b1;
    wst(3'd0);
    axr(`HBW_STATUS_OFS, d, r);
    chk({8'h0, d[23:8]}, {8'h0, `HBW_OVP_LOAD, `HBW_OCP_LOAD, `HBW_BURST_LOAD, 4'h0});
    axr(`HBW_CYCLES_OFS, d, r);
    chk(32'(d[15:0]), 32'h0);
    chk(32'(zf_seen), 32'h1);
    $display("test burst done");
    fb <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      {bias_overvoltage, ocp} <= 2'b01 << i;
      wst(3'd2);
      wst(3'd0);
    end
    {bias_overvoltage, ocp} <= 2'b00;
    $display("test fault done");
    slow <= 1'b1;
    axw(`HBW_CTRL_OFS, 32'h1, r);
    chk(32'(r), 32'h0);
    axr(`HBW_CTRL_OFS, d, r);
    chk(d, 32'h1);
    // Without byte lane 0 the control bit must keep its value
    ws <= 4'he;
    axw(`HBW_CTRL_OFS, 32'h0, r);
    axr(`HBW_CTRL_OFS, d, r);
    chk(d, 32'h1);
    ws <= 4'hf;
    wst(3'd4);
    $display("test timers done");
    en <= 1'b0;
    fb <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'({hg, lg, hr, lr, zf}), 32'h0);
    en <= 1'b1;
    repeat (12) @(posedge clk_i);
    axr(`HBW_STATUS_OFS, d, r);
    chk(32'(d[11:0]), {20'h0, `HBW_STARTUP_LOAD, 8'h00});
    $display("test abort done");
    end_of_test;
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    end_of_test;
  end
endmodule // hbw_wavegen_tb_top
